/* File: hw/aalm_pkg.sv */
// Package: register pointers, field layout and reset values for the alert window block
package aalm_pkg;
    // ------------------------------------------------------------
    // Register pointers
    // ------------------------------------------------------------
    localparam logic [7:0] PTR_ALERT_STATUS = 8'h01;
    localparam logic [7:0] PTR_CONFIG = 8'h02;
    localparam logic [7:0] PTR_UNDER_RANGE_LIMIT = 8'h03;
    localparam logic [7:0] PTR_OVER_RANGE_LIMIT = 8'h04;
    localparam logic [7:0] PTR_ALERT_HYSTERESIS = 8'h05;
    localparam logic [7:0] PTR_LOWEST_RESULT = 8'h06;
    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int CODE_W = 12;
    localparam int REG_W = 16;
    localparam int CFG_HOLD_BIT = 4;
    localparam int STAT_OVER_BIT = 1;
    localparam int STAT_UNDER_BIT = 0;
    localparam logic [11:0] FULL_SCALE = 12'hfff;
    localparam logic [11:0] ZERO_CODE = 12'h000;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [11:0] RST_UNDER_RANGE_LIMIT = 12'h000;
    localparam logic [11:0] RST_OVER_RANGE_LIMIT = 12'hfff;
    localparam logic [11:0] RST_ALERT_HYSTERESIS = 12'h000;
    localparam logic [11:0] RST_LOWEST_RESULT = 12'hfff;
    localparam logic [7:0] RST_CONFIG = 8'h00;
endpackage

/* File: hw/aalm_alert_flag.sv */
// One sticky alert flag with set, self-clear and write-one-to-clear
`timescale 1ns/1ps
`default_nettype none
module aalm_alert_flag (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic trip,
    input wire logic release_ok,
    input wire logic hold,
    input wire logic sw_clear,
    output logic flag
);
    logic flag_r;
    logic flag_nxt;

    // Set wins over any clear; self-clear blocked while held
    assign flag_nxt = trip ? 1'b1 :
                      (sw_clear | (release_ok & ~hold)) ? 1'b0 : flag_r; // RULE6 RULE7 RULE13

    // Flag register
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
        end
    end

    assign flag = flag_r;

    a_flag_held: assert property (@(posedge mclk) disable iff (!rstn)
        (flag_r && hold && !sw_clear) |=> flag_r) // RULE7
        else $error("held alert flag dropped");
endmodule
`default_nettype wire

/* File: hw/aalm_regs.sv */
// Alert window limits, hysteresis and lowest-result tracker register bank
// What this block does
// (RULE1) Bits 15:12 of these registers read zero
// (RULE2) Master writes zeros into bits 15:12
// (RULE3) Lower limit at 03h; below raises under-alert
// (RULE4) Upper limit at 04h; above raises over-alert
// (RULE5) Reset: upper 0fff, lower and hysteresis zero
// (RULE6) Self-clear only beyond limit by hysteresis
// (RULE7) Hold setting stops automatic alert clearing
// (RULE8) Smaller result overwrites lowest at 06h
// (RULE9) Result not smaller leaves lowest unchanged
// (RULE10) Writing 0fff restarts minimum tracking anytime
// (RULE11) Automatic mode updates lowest every conversion
// (RULE12) Hold is config bit 4; sticky until written
// (RULE13) Writing one clears over/under status bits
// (RULE14) Unsigned compares; clear levels saturate 0..4095
`timescale 1ns/1ps
`default_nettype none
module aalm_regs
    import aalm_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic reg_wr,
    input wire logic [7:0] reg_ptr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    input wire logic conv_done,
    input wire logic [11:0] conv_result,
    output logic over_alert,
    output logic under_alert,
    output logic auto_mode
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [11:0] under_range_limit_r;
    logic [11:0] over_range_limit_r;
    logic [11:0] alert_hysteresis_r;
    logic [11:0] lowest_result_r;
    logic [7:0] config_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic [11:0] lowest_result_nxt;

    // Pointer decode; one compare function reused by all write strobes, each with its own compare
    function automatic logic wr_hit(input logic w, input logic [7:0] p, input logic [7:0] s);
        wr_hit = w && (p == s);
    endfunction

    logic wr_under;
    logic wr_over;
    logic wr_hyst;
    logic wr_lowest;
    logic wr_config;
    logic wr_status;
    assign wr_under = wr_hit(reg_wr, reg_ptr, PTR_UNDER_RANGE_LIMIT);
    assign wr_over = wr_hit(reg_wr, reg_ptr, PTR_OVER_RANGE_LIMIT);
    assign wr_hyst = wr_hit(reg_wr, reg_ptr, PTR_ALERT_HYSTERESIS);
    assign wr_lowest = wr_hit(reg_wr, reg_ptr, PTR_LOWEST_RESULT);
    assign wr_config = wr_hit(reg_wr, reg_ptr, PTR_CONFIG);
    assign wr_status = wr_hit(reg_wr, reg_ptr, PTR_ALERT_STATUS);

    // Configuration fields
    logic alert_hold;
    assign alert_hold = config_r[CFG_HOLD_BIT]; // RULE12
    assign auto_mode = |config_r[7:5];

    // ------------------------------------------------------------
    // Window comparison
    // ------------------------------------------------------------
    // Saturating add and subtract keep codes in 0..4095
    function automatic logic [11:0] sat_add(input logic [11:0] a, input logic [11:0] b);
        logic [12:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[12] ? FULL_SCALE : s[11:0];
    endfunction

    function automatic logic [11:0] sat_sub(input logic [11:0] a, input logic [11:0] b);
        sat_sub = (a > b) ? (a - b) : ZERO_CODE;
    endfunction

    logic [11:0] over_clear_lvl;
    logic [11:0] under_clear_lvl;
    logic over_trip;
    logic under_trip;
    logic over_release;
    logic under_release;
    assign over_clear_lvl = sat_sub(over_range_limit_r, alert_hysteresis_r); // RULE14
    assign under_clear_lvl = sat_add(under_range_limit_r, alert_hysteresis_r); // RULE14
    assign over_trip = conv_done && (conv_result > over_range_limit_r); // RULE4
    assign under_trip = conv_done && (conv_result < under_range_limit_r); // RULE3
    assign over_release = conv_done && (conv_result < over_clear_lvl); // RULE6
    assign under_release = conv_done && (conv_result > under_clear_lvl); // RULE6

    // Write-one-to-clear strobes for the two flags
    logic over_sw_clear;
    logic under_sw_clear;
    assign over_sw_clear = wr_status && reg_wdata[STAT_OVER_BIT]; // RULE13
    assign under_sw_clear = wr_status && reg_wdata[STAT_UNDER_BIT]; // RULE13

    // Alert flags
    aalm_alert_flag u_over (
        .mclk(mclk),
        .rstn(rstn),
        .trip(over_trip),
        .release_ok(over_release),
        .hold(alert_hold),
        .sw_clear(over_sw_clear),
        .flag(over_alert)
    );

    aalm_alert_flag u_under (
        .mclk(mclk),
        .rstn(rstn),
        .trip(under_trip),
        .release_ok(under_release),
        .hold(alert_hold),
        .sw_clear(under_sw_clear),
        .flag(under_alert)
    );

    // ------------------------------------------------------------
    // Minimum tracking
    // ------------------------------------------------------------
    // A conversion below the stored minimum, in any conversion mode
    logic new_low;
    assign new_low = conv_done && (conv_result < lowest_result_r); // RULE8 RULE11

    // Bus write wins; otherwise a smaller result replaces the minimum
    assign lowest_result_nxt = wr_lowest ? reg_wdata[11:0] : // RULE10
        new_low ? conv_result : // RULE8 RULE11
        lowest_result_r; // RULE9

    // Register writes; limits keep bits 11:0, config keeps bits 7:2 and 0
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            under_range_limit_r <= RST_UNDER_RANGE_LIMIT; // RULE5
            over_range_limit_r <= RST_OVER_RANGE_LIMIT;
            alert_hysteresis_r <= RST_ALERT_HYSTERESIS;
            lowest_result_r <= RST_LOWEST_RESULT;
            config_r <= RST_CONFIG;
        end else begin
            if (wr_under) begin
                under_range_limit_r <= reg_wdata[11:0];
            end
            if (wr_over) begin
                over_range_limit_r <= reg_wdata[11:0];
            end
            if (wr_hyst) begin
                alert_hysteresis_r <= reg_wdata[11:0];
            end
            if (wr_config) begin
                config_r <= {reg_wdata[7:2], 1'b0, reg_wdata[0]};
            end
            lowest_result_r <= lowest_result_nxt;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Status word as read back
    logic [15:0] status_word;
    assign status_word = {14'h0, over_alert, under_alert};

    // Upper four bits always zero on the 12-bit registers
    always_comb begin
        unique case (reg_ptr)
            PTR_ALERT_STATUS: rdata_nxt = status_word;
            PTR_CONFIG: rdata_nxt = {8'h00, config_r};
            PTR_UNDER_RANGE_LIMIT: rdata_nxt = {4'h0, under_range_limit_r}; // RULE1
            PTR_OVER_RANGE_LIMIT: rdata_nxt = {4'h0, over_range_limit_r}; // RULE1
            PTR_ALERT_HYSTERESIS: rdata_nxt = {4'h0, alert_hysteresis_r}; // RULE1
            PTR_LOWEST_RESULT: rdata_nxt = {4'h0, lowest_result_r}; // RULE1
            default: rdata_nxt = 16'h0000;
        endcase
    end

    // Registered read data, one cycle after the pointer
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_rsvd_zero: assert property (@(posedge mclk) disable iff (!rstn) // RULE1
        (reg_ptr >= PTR_UNDER_RANGE_LIMIT && reg_ptr <= PTR_LOWEST_RESULT) |=> rdata_r[15:12] == 4'h0)
        else $error("reserved read bits not zero");
    a_under_trip: assert property (@(posedge mclk) disable iff (!rstn) // RULE3
        under_trip |=> under_alert)
        else $error("under-range alert not raised");
    a_over_trip: assert property (@(posedge mclk) disable iff (!rstn) // RULE4
        over_trip |=> over_alert)
        else $error("over-range alert not raised");
    a_over_stays: assert property (@(posedge mclk) disable iff (!rstn) // RULE6
        (over_alert && !(conv_done && conv_result < over_clear_lvl) && !wr_status) |=> over_alert)
        else $error("over alert cleared inside hysteresis band");
    a_hold_keeps: assert property (@(posedge mclk) disable iff (!rstn) // RULE7
        (under_alert && alert_hold && !wr_status) |=> under_alert)
        else $error("held under alert self-cleared");
    a_min_update: assert property (@(posedge mclk) disable iff (!rstn) // RULE8
        (conv_done && !wr_lowest && conv_result < lowest_result_r) |=>
        lowest_result_r == $past(conv_result))
        else $error("minimum not updated");
    a_min_keep: assert property (@(posedge mclk) disable iff (!rstn) // RULE9
        (!wr_lowest && !(conv_done && conv_result < lowest_result_r)) |=> $stable(lowest_result_r))
        else $error("minimum changed without smaller result");
    a_min_write: assert property (@(posedge mclk) disable iff (!rstn) // RULE10
        wr_lowest |=> lowest_result_r == $past(reg_wdata[11:0]))
        else $error("minimum write not taken");
    a_w1c_clear: assert property (@(posedge mclk) disable iff (!rstn) // RULE13
        (wr_status && reg_wdata[STAT_OVER_BIT] && !over_trip) |=> !over_alert)
        else $error("write one did not clear over flag");

    // ------------------------------------------------------------
    // Alert behaviour in steps
    // ------------------------------------------------------------
    // Conversion far enough back inside the over limit
    sequence s_over_release;
        conv_done && (conv_result < over_clear_lvl);
    endsequence
    // Conversion far enough back inside the under limit
    sequence s_under_release;
        conv_done && (conv_result > under_clear_lvl);
    endsequence
    // Conversion below the stored minimum with no bus write
    sequence s_new_low;
        conv_done && !wr_lowest && (conv_result < lowest_result_r);
    endsequence
    // Flags free to self-clear this cycle
    sequence s_free_run;
        !alert_hold && !wr_status;
    endsequence

    // Released over alert drops when not held
    a_over_self_clr: assert property (@(posedge mclk) disable iff (!rstn) // RULE6
        (over_alert ##0 s_free_run ##0 s_over_release) |=> !over_alert)
        else $error("over alert did not self-clear");
    // Released under alert drops when not held
    a_under_self_clr: assert property (@(posedge mclk) disable iff (!rstn) // RULE6
        (under_alert ##0 s_free_run ##0 s_under_release) |=> !under_alert)
        else $error("under alert did not self-clear");
    // Under alert stays inside the hysteresis band
    a_under_stays: assert property (@(posedge mclk) disable iff (!rstn) // RULE6
        (under_alert && !(conv_done && conv_result > under_clear_lvl) && !wr_status) |=>
        under_alert)
        else $error("under alert cleared inside hysteresis band");
    // Held over alert survives any conversion
    a_over_hold: assert property (@(posedge mclk) disable iff (!rstn) // RULE7 RULE12
        (over_alert && alert_hold && !over_sw_clear) |=> over_alert)
        else $error("held over alert self-cleared");
    // Write one clears the under flag
    a_under_w1c: assert property (@(posedge mclk) disable iff (!rstn) // RULE13
        (under_sw_clear && !under_trip) |=> !under_alert)
        else $error("write one did not clear under flag");
    // Clear levels never wrap past the code range
    a_clr_lvl_range: assert property (@(posedge mclk) disable iff (!rstn) // RULE14
        (under_clear_lvl >= under_range_limit_r) && (over_clear_lvl <= over_range_limit_r))
        else $error("self-clear level wrapped");
    // Hold bit follows the configuration write
    a_cfg_hold: assert property (@(posedge mclk) disable iff (!rstn) // RULE12
        wr_config |=> alert_hold == $past(reg_wdata[CFG_HOLD_BIT]))
        else $error("hold setting not taken");

    // ------------------------------------------------------------
    // Limits, minimum and read-back
    // ------------------------------------------------------------
    // Lower limit takes the written code
    a_under_write: assert property (@(posedge mclk) disable iff (!rstn) // RULE3
        wr_under |=> under_range_limit_r == $past(reg_wdata[11:0]))
        else $error("lower limit write not taken");
    // Upper limit takes the written code
    a_over_write: assert property (@(posedge mclk) disable iff (!rstn) // RULE4
        wr_over |=> over_range_limit_r == $past(reg_wdata[11:0]))
        else $error("upper limit write not taken");
    // Minimum drops on every smaller conversion in automatic mode
    a_auto_track: assert property (@(posedge mclk) disable iff (!rstn) // RULE11
        (auto_mode ##0 s_new_low) |=> lowest_result_r < $past(lowest_result_r))
        else $error("minimum not tracked in automatic mode");
    // Minimum only rises through a bus write
    a_min_no_rise: assert property (@(posedge mclk) disable iff (!rstn) // RULE9
        !wr_lowest |=> lowest_result_r <= $past(lowest_result_r))
        else $error("minimum rose without a write");
    // Minimum reads back with zero upper bits
    a_rd_lowest: assert property (@(posedge mclk) disable iff (!rstn) // RULE1
        (reg_ptr == PTR_LOWEST_RESULT) |=> reg_rdata == {4'h0, $past(lowest_result_r)})
        else $error("minimum read-back wrong");
    // Status reads back both flags
    a_status_rd: assert property (@(posedge mclk) disable iff (!rstn) // RULE13
        (reg_ptr == PTR_ALERT_STATUS) |=>
        reg_rdata == {14'h0, $past(over_alert), $past(under_alert)})
        else $error("status read-back wrong");

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    // Registers hold their reset codes at the first edge after release
    a_reset_vals: assert property (@(posedge mclk) // RULE5
        $rose(rstn) |-> (under_range_limit_r == RST_UNDER_RANGE_LIMIT) &&
        (over_range_limit_r == RST_OVER_RANGE_LIMIT) &&
        (alert_hysteresis_r == RST_ALERT_HYSTERESIS) &&
        (lowest_result_r == RST_LOWEST_RESULT) && !over_alert && !under_alert)
        else $error("registers not at reset values after release");
endmodule
`default_nettype wire

/* File: test/aalm_host_model.sv */
// Register-port master model standing in for the serial bus controller
`timescale 1ns/1ps
`default_nettype none
module aalm_host_model (
    input wire logic mclk,
    input wire logic [15:0] reg_rdata,
    output logic reg_wr,
    output logic [7:0] reg_ptr,
    output logic [15:0] reg_wdata,
    output logic conv_done,
    output logic [11:0] conv_result
);
    // Idle values from time zero
    initial begin
        reg_wr = 1'b0;
        reg_ptr = 8'h00;
        reg_wdata = 16'h0000;
        conv_done = 1'b0;
        conv_result = 12'h000;
    end
    // Whole word write; callers keep 15:12 zero unless probing the read mask
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        @(negedge mclk);
        reg_ptr = p;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_wdata = ~d; // Stale data is not left on the bus
    endtask
    // Select, then wait out the registered read path
    task automatic rd(input logic [7:0] p, output logic [15:0] d);
        @(negedge mclk);
        reg_ptr = p;
        @(negedge mclk);
        @(negedge mclk);
        d = reg_rdata;
    endtask
    // One conversion pulse
    task automatic conv(input logic [11:0] r);
        @(negedge mclk);
        conv_result = r;
        conv_done = 1'b1;
        @(negedge mclk);
        conv_done = 1'b0;
        conv_result = ~r;
    endtask
endmodule
`default_nettype wire

/* File: test/tb_aalm_regs.sv */
// Self-checking bench for the alert window register bank
`timescale 1ns/1ps
`default_nettype none
module tb_aalm_regs;
    import aalm_pkg::*;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic reg_wr, conv_done, over_alert, under_alert, auto_mode;
    logic [7:0] reg_ptr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [11:0] conv_result;
    int mismatches = 0;
    int checks_done = 0;
    always #5 mclk = ~mclk;
    aalm_regs i_aalm_regs (.mclk(mclk), .rstn(rstn), .reg_wr(reg_wr), .reg_ptr(reg_ptr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .conv_done(conv_done),
        .conv_result(conv_result), .over_alert(over_alert), .under_alert(under_alert),
        .auto_mode(auto_mode));
    aalm_host_model i_aalm_host_model (.mclk(mclk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_ptr(reg_ptr), .reg_wdata(reg_wdata), .conv_done(conv_done),
        .conv_result(conv_result));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [7:0] p, input logic [15:0] d);
        i_aalm_host_model.wr(p, d);
    endtask
    task automatic c(input logic [11:0] r);
        i_aalm_host_model.conv(r);
    endtask
    task automatic rchk(input logic [7:0] p, input logic [15:0] exp);
        logic [15:0] d;
        i_aalm_host_model.rd(p, d);
        chk(d, exp);
    endtask
    task automatic achk(input logic o, input logic u);
        chk({14'h0, over_alert, under_alert}, {14'h0, o, u});
    endtask
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        rchk(PTR_UNDER_RANGE_LIMIT, 16'h0000);
        rchk(PTR_OVER_RANGE_LIMIT, 16'h0fff);
        rchk(PTR_ALERT_HYSTERESIS, 16'h0000);
        rchk(PTR_LOWEST_RESULT, 16'h0fff);
        achk(1'b0, 1'b0);
        $display("done t_reset");
    endtask
    task automatic t_fields;
        for (logic [7:0] p = 8'h03; p < 8'h07; p++) begin
            w(p, 16'hf5a5);
            rchk(p, 16'h05a5);
        end
        w(8'h09, 16'h0123);
        rchk(8'h09, 16'h0000);
        w(PTR_OVER_RANGE_LIMIT, 16'h0fff);
        $display("done t_fields");
    endtask
    task automatic t_under;
        w(PTR_UNDER_RANGE_LIMIT, 16'h0100);
        w(PTR_ALERT_HYSTERESIS, 16'h0010);
        w(PTR_LOWEST_RESULT, 16'h0fff);
        c(12'h100);
        achk(1'b0, 1'b0);
        c(12'h0ff);
        achk(1'b0, 1'b1);
        c(12'h110);
        achk(1'b0, 1'b1);
        c(12'h111);
        achk(1'b0, 1'b0);
        rchk(PTR_LOWEST_RESULT, 16'h00ff);
        $display("done t_under");
    endtask
    task automatic t_over;
        w(PTR_OVER_RANGE_LIMIT, 16'h0800);
        c(12'h800);
        achk(1'b0, 1'b0);
        c(12'h801);
        achk(1'b1, 1'b0);
        c(12'h7f0);
        achk(1'b1, 1'b0);
        c(12'h7ef);
        achk(1'b0, 1'b0);
        $display("done t_over");
    endtask
    task automatic t_hold;
        w(PTR_CONFIG, 16'h0010);
        c(12'h900);
        c(12'h000);
        achk(1'b1, 1'b1);
        c(12'h400);
        achk(1'b1, 1'b1);
        w(PTR_ALERT_STATUS, 16'h0002);
        achk(1'b0, 1'b1);
        w(PTR_ALERT_STATUS, 16'h0001);
        achk(1'b0, 1'b0);
        w(PTR_CONFIG, 16'h0000);
        $display("done t_hold");
    endtask
    task automatic t_sat;
        w(PTR_OVER_RANGE_LIMIT, 16'h0005);
        w(PTR_UNDER_RANGE_LIMIT, 16'h0000);
        c(12'h006);
        c(12'h000);
        achk(1'b1, 1'b0);
        w(PTR_ALERT_STATUS, 16'h0002);
        w(PTR_OVER_RANGE_LIMIT, 16'h0fff);
        w(PTR_UNDER_RANGE_LIMIT, 16'h0ff8);
        c(12'hff0);
        c(12'hfff);
        achk(1'b0, 1'b1);
        $display("done t_sat");
    endtask
    task automatic t_min;
        w(PTR_LOWEST_RESULT, 16'h0fff);
        rchk(PTR_LOWEST_RESULT, 16'h0fff);
        w(PTR_CONFIG, 16'h0020);
        chk({15'h0, auto_mode}, 16'h0001);
        c(12'h300);
        c(12'h200);
        c(12'h250);
        rchk(PTR_LOWEST_RESULT, 16'h0200);
        w(PTR_CONFIG, 16'h0000);
        $display("done t_min");
    endtask
    task automatic t_rerst;
        w(PTR_UNDER_RANGE_LIMIT, 16'h0123);
        @(negedge mclk);
        rstn = 1'b0;
        repeat (2) @(negedge mclk);
        rstn = 1'b1;
        rchk(PTR_UNDER_RANGE_LIMIT, 16'h0000);
        rchk(PTR_LOWEST_RESULT, 16'h0fff);
        achk(1'b0, 1'b0);
        $display("done t_rerst");
    endtask
    // Watchdog well beyond the 140 or so cycles the scenarios need
    initial begin
        #200000;
        mismatches++;
        close_out;
    end
    initial begin
        repeat (10) @(negedge mclk);
        rstn = 1'b1;
        t_reset;
        t_fields;
        t_under;
        t_over;
        t_hold;
        t_sat;
        t_min;
        t_rerst;
        close_out;
    end
endmodule
`default_nettype wire
